/* File: core_regs_params.svh */
// Purpose: offsets, fields and reset values
// Assumes: 8-bit register port, byte offsets as printed
// Notes:   definitions only
`ifndef CORE_REGS_PARAMS_SVH
`define CORE_REGS_PARAMS_SVH

// register offsets, both banks where mirrored
`define ADDR_TIMER        8'h01
`define ADDR_STATUS_B0    8'h03
`define ADDR_STATUS_B1    8'h83
`define ADDR_IC_B0        8'h0B
`define ADDR_IC_B1        8'h8B
`define ADDR_OPTION       8'h81
`define ADDR_PERIPH_FLAGS 8'h0C
`define ADDR_PERIPH_EN    8'h8C

// status fields
`define ST_CARRY   0
`define ST_DIGIT   1
`define ST_ZERO    2
`define ST_PWD     3
`define ST_TMO     4
`define ST_BANK    5

// option fields
`define OP_RATE_LSB 0
`define OP_ASSIGN   3
`define OP_SRC_EDGE 4
`define OP_CLK_SRC  5
`define OP_INT_EDGE 6
`define OP_PU_DIS   7

// interrupt control fields
`define IC_PCF  0
`define IC_EXTF 1
`define IC_TOVF 2
`define IC_PCE  3
`define IC_EXTE 4
`define IC_TOVE 5
`define IC_PGEN 6
`define IC_GEN  7

// implemented peripheral bits
`define PERIPH_MASK 8'hC9

// reset values
`define RST_STATUS  8'h18
`define RST_OPTION  8'hFF
`define RST_INTERRUPT_CONTROL  8'h00
`define RST_PERIPH  8'h00
`define RST_TIMER   8'h00

`endif

/* File: core_regs_pkg.sv */
// Purpose: types shared by the core register group
// Assumes: nothing
// Notes:   flag-reporting operation class
package core_regs_pkg;
    typedef enum logic [2:0] {
        ALU_ADD   = 3'h0,
        ALU_SUB   = 3'h1,
        ALU_LOGIC = 3'h2,
        ALU_ROTL  = 3'h3,
        ALU_ROTR  = 3'h4
    } alu_op_e;
endpackage

/* File: core_status_option_irq_regs.sv */
// Purpose: status, option, interrupt control and peripheral enable/flag registers
// Assumes: mclk_i is the instruction clock; pins are asynchronous
// Notes:   timer and prescaler live here
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_params.svh"

// Contract
// - flag-updating instructions override written flags
// - timeout and powerdown flags are read-only
// - bank select picks upper or lower bank
// - timeout and powerdown flags follow power events
// - zero flag follows result being zero
// - digit carry from low nibble, inverted borrow
// - carry from MSB, subtract via two's complement
// - rotates load carry with shifted-out bit
// - pull-up disable overrides per-pin enables
// - edge select chooses external interrupt edge
// - timer source internal or pin, edge selectable
// - prescaler goes to watchdog or timer
// - rate divides 2^(n+1) timer, 2^n watchdog
// - flags set regardless of enables
// - global and peripheral enables gate interrupts
// - timer rollover sets overflow flag
// - selected pin edge sets external flag
// - port pin change sets change flag
// - peripheral enable holds four bits only
// - peripheral flags set by events, software clears
module core_status_option_irq_regs
    import core_regs_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic       alu_valid_i,
    input  wire alu_op_e    alu_op_i,
    input  wire logic [7:0] alu_a_i,
    input  wire logic [7:0] alu_b_i,
    input  wire logic [7:0] alu_result_i,
    input  wire logic       watchdog_clear_instr_i,
    input  wire logic       sleep_instr_i,
    input  wire logic       watchdog_timeout_i,
    input  wire logic       watchdog_tick_i,
    input  wire logic       ext_irq_pin_i,
    input  wire logic       ext_timer_clock_pin_i,
    input  wire logic [5:0] port_pins_i,
    input  wire logic [5:0] pin_change_mask_i,
    input  wire logic [5:0] pullup_latch_i,
    input  wire logic       mem_write_done_i,
    input  wire logic       conversion_done_i,
    input  wire logic       comparator_change_i,
    input  wire logic       wide_timer_overflow_i,
    output logic            bank_select_o,
    output logic      [5:0] pullup_en_o,
    output logic            watchdog_prescaled_o,
    output logic            irq_o
);

    // ******************************
    // helpers
    // ******************************

    // mask ending one divided period
    function automatic logic [7:0] rate_mask(input logic [2:0] n, input logic plus_one);
        logic [8:0] m;
        m = (9'h001 << ({6'h00, n} + {8'h00, plus_one})) - 9'h001;
        return m[7:0];
    endfunction

    // decode for read and write
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1);
        return (a == b0) || (a == b1);
    endfunction

    // ******************************
    // registers and decode
    // ******************************

    logic [7:0] status;
    logic [7:0] option;
    logic [7:0] ictl;
    logic [7:0] periph_en;
    logic [7:0] periph_flags;
    logic [7:0] timer;
    logic [7:0] prescale_cnt;
    logic [5:0] changed_pins;

    logic wr_status;
    logic wr_ictl;
    logic wr_option;
    logic wr_pen;
    logic wr_pflags;
    logic wr_timer;

    // write strobes per register, mirrors included
    assign wr_status = reg_wr_i && hit(reg_addr_i, `ADDR_STATUS_B0, `ADDR_STATUS_B1);
    assign wr_ictl   = reg_wr_i && hit(reg_addr_i, `ADDR_IC_B0, `ADDR_IC_B1);
    assign wr_option = reg_wr_i && (reg_addr_i == `ADDR_OPTION);
    assign wr_pen    = reg_wr_i && (reg_addr_i == `ADDR_PERIPH_EN);
    assign wr_pflags = reg_wr_i && (reg_addr_i == `ADDR_PERIPH_FLAGS);
    assign wr_timer  = reg_wr_i && (reg_addr_i == `ADDR_TIMER);

    // ******************************
    // flag computation
    // ******************************

    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] opnd_b;
    logic       cin;
    logic       upd_z;
    logic       upd_dc;
    logic       upd_c;
    logic       new_z;
    logic       new_dc;
    logic       new_c;

    // subtract adds the two's complement of b
    always_comb begin
        opnd_b = (alu_op_i == ALU_SUB) ? ~alu_b_i : alu_b_i;
        cin    = (alu_op_i == ALU_SUB);
        sum9   = {1'b0, alu_a_i} + {1'b0, opnd_b} + {8'h00, cin};
        sum5   = {1'b0, alu_a_i[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
        upd_z  = 1'b0;
        upd_dc = 1'b0;
        upd_c  = 1'b0;
        new_z  = (alu_result_i == 8'h00);
        new_dc = sum5[4];
        new_c  = sum9[8];
        case (alu_op_i)
            ALU_ADD, ALU_SUB: begin
                upd_z  = 1'b1;
                upd_dc = 1'b1;
                upd_c  = 1'b1;
                new_z  = (sum9[7:0] == 8'h00);
            end
            ALU_LOGIC: begin
                upd_z = 1'b1;
            end
            ALU_ROTL: begin
                upd_c = 1'b1;
                new_c = alu_a_i[7];
            end
            ALU_ROTR: begin
                upd_c = 1'b1;
                new_c = alu_a_i[0];
            end
            default: begin
                upd_z = 1'b0;
            end
        endcase
    end

    // ******************************
    // status register
    // ******************************

    // instruction flags beat a same-cycle write
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            status <= `RST_STATUS;
        end else begin
            if (wr_status) begin
                status[7:5]         <= reg_wdata_i[7:5];
                status[`ST_ZERO]    <= reg_wdata_i[`ST_ZERO];
                status[`ST_DIGIT]   <= reg_wdata_i[`ST_DIGIT];
                status[`ST_CARRY]   <= reg_wdata_i[`ST_CARRY];
            end
            if (alu_valid_i && upd_z) begin
                status[`ST_ZERO] <= new_z;
            end
            if (alu_valid_i && upd_dc) begin
                status[`ST_DIGIT] <= new_dc;
            end
            if (alu_valid_i && upd_c) begin
                status[`ST_CARRY] <= new_c;
            end
            // power flags ignore writes
            if (watchdog_timeout_i) begin
                status[`ST_TMO] <= 1'b0;
            end else if (watchdog_clear_instr_i || sleep_instr_i) begin
                status[`ST_TMO] <= 1'b1;
            end
            if (sleep_instr_i) begin
                status[`ST_PWD] <= 1'b0;
            end else if (watchdog_clear_instr_i) begin
                status[`ST_PWD] <= 1'b1;
            end
        end
    end

    // bank for direct addressing
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            bank_select_o <= 1'(`RST_STATUS >> `ST_BANK);
        end else begin
            bank_select_o <= wr_status ? reg_wdata_i[`ST_BANK] : status[`ST_BANK];
        end
    end

    // ******************************
    // option register and pull-ups
    // ******************************

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            option <= `RST_OPTION;
        end else if (wr_option) begin
            option <= reg_wdata_i;
        end
    end

    // disable overrides per-pin latches
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pullup_en_o <= 6'h00;
        end else begin
            pullup_en_o <= option[`OP_PU_DIS] ? 6'h00 : pullup_latch_i;
        end
    end

    // ******************************
    // pin synchronisers
    // ******************************

    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] sync3;

    // three stages; a change counts when stages two and three differ
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= 8'h00;
            sync2 <= 8'h00;
            sync3 <= 8'h00;
        end else begin
            sync1 <= {ext_timer_clock_pin_i, ext_irq_pin_i, port_pins_i};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    logic [5:0] pin_toggle;
    logic       ext_rise;
    logic       ext_fall;
    logic       tpin_rise;
    logic       tpin_fall;
    logic       ext_event;

    assign pin_toggle = sync2[5:0] ^ sync3[5:0];
    assign ext_rise   = sync2[6] & ~sync3[6];
    assign ext_fall   = ~sync2[6] & sync3[6];
    assign tpin_rise  = sync2[7] & ~sync3[7];
    assign tpin_fall  = ~sync2[7] & sync3[7];
    assign ext_event  = option[`OP_INT_EDGE] ? ext_rise : ext_fall;

    // ******************************
    // timer and shared prescaler
    // ******************************

    logic       src_tick;
    logic       pre_in;
    logic       pre_out;
    logic       tmr_inc;
    logic       tmr_roll;
    logic [7:0] pmask;

    // pin edge or every cycle; edge one means falling
    assign src_tick = option[`OP_CLK_SRC] ?
                      (option[`OP_SRC_EDGE] ? tpin_fall : tpin_rise) : 1'b1;
    assign pre_in   = option[`OP_ASSIGN] ? watchdog_tick_i : src_tick;
    assign pmask    = rate_mask(option[2:0], ~option[`OP_ASSIGN]);
    assign pre_out  = pre_in && ((prescale_cnt & pmask) == pmask);
    assign tmr_inc  = option[`OP_ASSIGN] ? src_tick : pre_out;
    assign tmr_roll = tmr_inc && (timer == 8'hFF) && !wr_timer;

    // timer write restarts prescaler
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prescale_cnt <= 8'h00;
        end else if (wr_timer) begin
            prescale_cnt <= 8'h00;
        end else if (pre_in) begin
            prescale_cnt <= pre_out ? 8'h00 : prescale_cnt + 8'h01;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            timer <= `RST_TIMER;
        end else if (wr_timer) begin
            timer <= reg_wdata_i;
        end else if (tmr_inc) begin
            timer <= timer + 8'h01;
        end
    end

    // watchdog tick, divided only when the prescaler is assigned to the watchdog
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            watchdog_prescaled_o <= 1'b0;
        end else begin
            watchdog_prescaled_o <= option[`OP_ASSIGN] ? pre_out : watchdog_tick_i;
        end
    end

    // ******************************
    // interrupt control
    // ******************************

    // events set flags whatever the enables; set wins
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ictl <= `RST_INTERRUPT_CONTROL;
        end else begin
            if (wr_ictl) begin
                ictl <= reg_wdata_i;
            end
            if (tmr_roll) begin
                ictl[`IC_TOVF] <= 1'b1;
            end
            if (ext_event) begin
                ictl[`IC_EXTF] <= 1'b1;
            end
            if (|pin_toggle) begin
                ictl[`IC_PCF] <= 1'b1;
            end
        end
    end

    // pins changed since the flag was cleared
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            changed_pins <= 6'h00;
        end else if (wr_ictl && !reg_wdata_i[`IC_PCF]) begin
            changed_pins <= pin_toggle;
        end else begin
            changed_pins <= changed_pins | pin_toggle;
        end
    end

    // ******************************
    // peripheral enables and flags
    // ******************************

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            periph_en <= `RST_PERIPH;
        end else if (wr_pen) begin
            periph_en <= reg_wdata_i & `PERIPH_MASK;
        end
    end

    logic [7:0] periph_events;

    assign periph_events = {mem_write_done_i, conversion_done_i, 2'b00,
                            comparator_change_i, 2'b00, wide_timer_overflow_i};

    // events set flags; software clears by writing zero
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            periph_flags <= `RST_PERIPH;
        end else begin
            periph_flags <= ((wr_pflags ? reg_wdata_i : periph_flags) | periph_events)
                            & `PERIPH_MASK;
        end
    end

    // ******************************
    // interrupt request
    // ******************************

    logic core_req;
    logic periph_req;

    assign core_req   = (ictl[`IC_TOVE] & ictl[`IC_TOVF])
                      | (ictl[`IC_EXTE] & ictl[`IC_EXTF])
                      | (ictl[`IC_PCE] & ictl[`IC_PCF]
                         & |(changed_pins & pin_change_mask_i));
    assign periph_req = ictl[`IC_PGEN] & |(periph_en & periph_flags);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= ictl[`IC_GEN] & (core_req | periph_req);
        end
    end

    // ******************************
    // read port
    // ******************************

    // data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            if (hit(reg_addr_i, `ADDR_STATUS_B0, `ADDR_STATUS_B1)) begin
                reg_rdata_o <= status;
            end else if (hit(reg_addr_i, `ADDR_IC_B0, `ADDR_IC_B1)) begin
                reg_rdata_o <= ictl;
            end else if (reg_addr_i == `ADDR_OPTION) begin
                reg_rdata_o <= option;
            end else if (reg_addr_i == `ADDR_PERIPH_EN) begin
                reg_rdata_o <= periph_en;
            end else if (reg_addr_i == `ADDR_PERIPH_FLAGS) begin
                reg_rdata_o <= periph_flags;
            end else if (reg_addr_i == `ADDR_TIMER) begin
                reg_rdata_o <= timer;
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

endmodule // core_status_option_irq_regs

`default_nettype wire

/* File: core_status_option_irq_regs_assertions.sv */
// Purpose: port-level checks for the core register group
// Assumes: shadows track register writes
// Notes:   bound to the register group
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_params.svh"

// ****************************************
// checker module
// ****************************************
module core_regs_checker (
    input wire logic       mclk_i,
    input wire logic       rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       watchdog_tick_i,
    input wire logic [5:0] pullup_latch_i,
    input wire logic       bank_select_o,
    input wire logic [5:0] pullup_en_o,
    input wire logic       watchdog_prescaled_o,
    input wire logic       irq_o
);
    logic pu_dis;
    logic glob_en;
    logic wd_one;
    logic wr_st;
    logic wr_ic;
    logic wr_op;

    // decoded writes
    assign wr_st = reg_wr_i && (reg_addr_i == `ADDR_STATUS_B0 || reg_addr_i == `ADDR_STATUS_B1);
    assign wr_ic = reg_wr_i && (reg_addr_i == `ADDR_IC_B0 || reg_addr_i == `ADDR_IC_B1);
    assign wr_op = reg_wr_i && (reg_addr_i == `ADDR_OPTION);

    // option shadow
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pu_dis <= 1'b1;
            wd_one <= 1'b0;
        end else if (wr_op) begin
            pu_dis <= reg_wdata_i[`OP_PU_DIS];
            wd_one <= reg_wdata_i[`OP_ASSIGN] && (reg_wdata_i[2:0] == 3'h0);
        end
    end

    // enable shadow
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            glob_en <= 1'b0;
        end else if (wr_ic) begin
            glob_en <= reg_wdata_i[`IC_GEN];
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence s_bank_wr;
        wr_st ##1 !wr_st;
    endsequence
    sequence s_arm;
        (wr_ic && reg_wdata_i[`IC_GEN] && reg_wdata_i[`IC_EXTE] && reg_wdata_i[`IC_EXTF]) ##1 !wr_ic;
    endsequence

    property p_bank;
        s_bank_wr |=> bank_select_o == $past(reg_wdata_i[`ST_BANK], 2);
    endproperty
    property p_pu_off;
        $past(pu_dis) |-> pullup_en_o == 6'h00;
    endproperty
    property p_pu_follow;
        !$past(pu_dis) |-> pullup_en_o == $past(pullup_latch_i);
    endproperty
    property p_irq_gate;
        irq_o |-> $past(glob_en);
    endproperty
    property p_irq_raise;
        s_arm |=> irq_o;
    endproperty
    property p_periph_zero;
        reg_rd_i && (reg_addr_i == `ADDR_PERIPH_EN || reg_addr_i == `ADDR_PERIPH_FLAGS)
            |=> (reg_rdata_o & 8'h36) == 8'h00;
    endproperty
    property p_wd_one;
        wd_one && watchdog_tick_i && !wr_op |=> watchdog_prescaled_o;
    endproperty
    property p_wd_cause;
        watchdog_prescaled_o |-> $past(watchdog_tick_i);
    endproperty
    property p_rd_idle;
        reg_rdata_o != 8'h00 |-> $past(reg_rd_i);
    endproperty

    a_bank:        assert property (p_bank) else $error("bank output differs from write");
    a_pu_off:      assert property (p_pu_off) else $error("pull-ups on while disabled");
    a_pu_follow:   assert property (p_pu_follow) else $error("pull-ups ignore latches");
    a_irq_gate:    assert property (p_irq_gate) else $error("request without global enable");
    a_irq_raise:   assert property (p_irq_raise) else $error("enabled flag gave no request");
    a_periph_zero: assert property (p_periph_zero) else $error("unused peripheral bit set");
    a_wd_one:      assert property (p_wd_one) else $error("watchdog 1:1 pulse missing");
    a_wd_cause:    assert property (p_wd_cause) else $error("watchdog pulse without tick");
    a_rd_idle:     assert property (p_rd_idle) else $error("read data outside read slot");
endmodule // core_regs_checker

bind core_status_option_irq_regs core_regs_checker i_chk (
    .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .watchdog_tick_i(watchdog_tick_i), .pullup_latch_i(pullup_latch_i),
    .bank_select_o(bank_select_o), .pullup_en_o(pullup_en_o),
    .watchdog_prescaled_o(watchdog_prescaled_o), .irq_o(irq_o)
);
`default_nettype wire

/* File: core_status_option_irq_regs_tb.sv */
// Purpose: bench for the core register group
// Assumes: reset values and port timing
// Notes:   one task per scenario
`timescale 1ns/10ps
`default_nettype none
`include "core_regs_params.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module core_status_option_irq_regs_tb import core_regs_pkg::*;;
    logic       mclk_i = 0;
    logic       rst_i = 1;
    logic [7:0] addr = 0, wdata = 0, a = 0, b = 0, r = 0, rdat;
    logic       wr = 0, rd = 0, alu_v = 0, ext = 0, tp = 0, tick = 0, bank, wdp, irq;
    alu_op_e    op = ALU_ADD;
    logic [2:0] pw = 0;
    logic [3:0] pe = 0;
    logic [5:0] port = 0, cmask = 0, latch = 0, pu;
    int         fail_count = 0, samples_checked = 0, wpc = 0;

    core_status_option_irq_regs i_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdat), .alu_valid_i(alu_v), .alu_op_i(op), .alu_a_i(a),
        .alu_b_i(b), .alu_result_i(r), .watchdog_clear_instr_i(pw[0]), .sleep_instr_i(pw[1]),
        .watchdog_timeout_i(pw[2]), .watchdog_tick_i(tick), .ext_irq_pin_i(ext),
        .ext_timer_clock_pin_i(tp), .port_pins_i(port), .pin_change_mask_i(cmask),
        .pullup_latch_i(latch), .mem_write_done_i(pe[3]), .conversion_done_i(pe[2]),
        .comparator_change_i(pe[1]), .wide_timer_overflow_i(pe[0]), .bank_select_o(bank),
        .pullup_en_o(pu), .watchdog_prescaled_o(wdp), .irq_o(irq)
    );

    // ****************************************
    // clock and bus tasks
    // ****************************************
    initial begin
        forever #2 mclk_i = ~mclk_i;
    end

    // watchdog pulses
    always @(posedge mclk_i) begin
        if (wdp === 1'b1) wpc++;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic chk_reg(input string nm, input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e);
        addr <= ad;
        rd <= 1'b1;
        @(posedge mclk_i);
        rd <= 1'b0;
        #1;
        `CHK(nm, e, rdat & m)
        @(posedge mclk_i);
    endtask

    // output after n edges: 0 irq, 1 bank, 2 pull-ups
    task automatic look(input string nm, input int n, input int s, input logic [7:0] e);
        cyc(n);
        #1;
        case (s)
            0: `CHK(nm, e, {7'h00, irq})
            1: `CHK(nm, e, {7'h00, bank})
            default: `CHK(nm, e, {2'h0, pu})
        endcase
        @(posedge mclk_i);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        chk_reg("status rst", `ADDR_STATUS_B0, 8'hFF, 8'h18);
        chk_reg("option rst", `ADDR_OPTION, 8'hFF, 8'hFF);
        chk_reg("ictl rst", `ADDR_IC_B0, 8'hFF, 8'h00);
        chk_reg("pie rst", `ADDR_PERIPH_EN, 8'hFF, 8'h00);
        chk_reg("unmapped", 8'h50, 8'hFF, 8'h00);
        look("irq rst", 0, 0, 8'h00);
        $display("done reset");
    endtask

    task automatic t_status();
        wr_reg(`ADDR_STATUS_B0, 8'h27);
        chk_reg("status wr", `ADDR_STATUS_B1, 8'hFF, 8'h3F);
        look("bank hi", 0, 1, 8'h01);
        wr_reg(`ADDR_STATUS_B1, 8'h00);
        chk_reg("status clr", `ADDR_STATUS_B0, 8'hFF, 8'h18);
        look("bank lo", 0, 1, 8'h00);
        $display("done status");
    endtask

    task automatic t_alu();
        alu_op_e    ops [7] = '{ALU_ADD, ALU_ADD, ALU_SUB, ALU_SUB, ALU_LOGIC, ALU_ROTL, ALU_ROTR};
        logic [7:0] as [7] = '{8'h0F, 8'hF0, 8'h05, 8'h03, 8'h00, 8'h7F, 8'hFE};
        logic [7:0] bs [7] = '{8'h01, 8'h10, 8'h05, 8'h05, 8'h00, 8'h00, 8'h00};
        logic [7:0] rs [7] = '{8'h10, 8'h00, 8'h00, 8'hFE, 8'h05, 8'hFE, 8'h7F};
        logic [7:0] ex [7] = '{8'h1A, 8'h1D, 8'h1F, 8'h18, 8'h1B, 8'h1E, 8'h1E};
        for (int i = 0; i < 7; i++) begin
            op <= ops[i];
            a <= as[i];
            b <= bs[i];
            r <= rs[i];
            alu_v <= 1'b1;
            addr <= `ADDR_STATUS_B0;
            wdata <= 8'h07;
            wr <= 1'b1;
            @(posedge mclk_i);
            alu_v <= 1'b0;
            wr <= 1'b0;
            @(posedge mclk_i);
            chk_reg("alu flags", `ADDR_STATUS_B0, 8'hFF, ex[i]);
        end
        $display("done alu");
    endtask

    task automatic t_power();
        int         ks [3] = '{1, 2, 0};
        logic [7:0] ex [3] = '{8'h10, 8'h00, 8'h18};
        for (int i = 0; i < 3; i++) begin
            pw <= 3'(1 << ks[i]);
            @(posedge mclk_i);
            pw <= 3'h0;
            @(posedge mclk_i);
            chk_reg("power bits", `ADDR_STATUS_B0, 8'h18, ex[i]);
        end
        $display("done power");
    endtask

    task automatic t_option();
        latch <= 6'h2A;
        wr_reg(`ADDR_OPTION, 8'h28);
        look("pullup on", 2, 2, 8'h2A);
        wr_reg(`ADDR_TIMER, 8'h00);
        tp <= 1'b1;
        cyc(6);
        chk_reg("pin tick", `ADDR_TIMER, 8'hFF, 8'h01);
        wr_reg(`ADDR_OPTION, 8'hA8);
        look("pullup off", 2, 2, 8'h00);
        for (int n = 0; n < 3; n += 2) begin
            wr_reg(`ADDR_OPTION, 8'h08 | 8'(n));
            wpc = 0;
            repeat (8) begin
                tick <= 1'b1;
                @(posedge mclk_i);
                tick <= 1'b0;
                @(posedge mclk_i);
            end
            cyc(2);
            `CHK("wdt div", 8 >> n, wpc)
        end
        $display("done option");
    endtask

    task automatic t_timer();
        wr_reg(`ADDR_OPTION, 8'h08);
        wr_reg(`ADDR_TIMER, 8'hF0);
        wr_reg(`ADDR_IC_B0, 8'h00);
        chk_reg("no ovf", `ADDR_IC_B0, 8'h04, 8'h00);
        cyc(20);
        chk_reg("ovf", `ADDR_IC_B1, 8'h04, 8'h04);
        $display("done timer");
    endtask

    task automatic t_irq();
        wr_reg(`ADDR_OPTION, 8'h48);
        wr_reg(`ADDR_IC_B0, 8'h00);
        ext <= 1'b1;
        cyc(8);
        chk_reg("ext rise", `ADDR_IC_B0, 8'h02, 8'h02);
        look("irq masked", 0, 0, 8'h00);
        wr_reg(`ADDR_IC_B0, 8'h92);
        look("irq ext", 2, 0, 8'h01);
        wr_reg(`ADDR_IC_B0, 8'h12);
        look("irq gated", 2, 0, 8'h00);
        wr_reg(`ADDR_IC_B0, 8'h00);
        ext <= 1'b0;
        cyc(8);
        chk_reg("fall ignored", `ADDR_IC_B0, 8'h02, 8'h00);
        wr_reg(`ADDR_OPTION, 8'h08);
        ext <= 1'b1;
        cyc(8);
        ext <= 1'b0;
        cyc(8);
        chk_reg("fall taken", `ADDR_IC_B0, 8'h02, 8'h02);
        wr_reg(`ADDR_IC_B0, 8'h00);
        cmask <= 6'h04;
        port <= 6'h04;
        cyc(8);
        chk_reg("pin change", `ADDR_IC_B0, 8'h01, 8'h01);
        wr_reg(`ADDR_IC_B0, 8'h89);
        look("irq change", 2, 0, 8'h01);
        wr_reg(`ADDR_IC_B0, 8'h00);
        $display("done irq");
    endtask

    task automatic t_periph();
        wr_reg(`ADDR_PERIPH_EN, 8'hFF);
        chk_reg("pie bits", `ADDR_PERIPH_EN, 8'hFF, 8'hC9);
        pe <= 4'hF;
        @(posedge mclk_i);
        pe <= 4'h0;
        cyc(2);
        chk_reg("pir bits", `ADDR_PERIPH_FLAGS, 8'hFF, 8'hC9);
        wr_reg(`ADDR_IC_B0, 8'hC0);
        look("irq periph", 2, 0, 8'h01);
        wr_reg(`ADDR_PERIPH_FLAGS, 8'h00);
        look("irq cleared", 2, 0, 8'h00);
        wr_reg(`ADDR_IC_B0, 8'h00);
        $display("done periph");
    endtask

    // ****************************************
    // run control
    // ****************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        cyc(5000);
        fail_count++;
        final_report();
    end

    initial begin
        cyc(8);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        t_reset();
        t_status();
        t_alu();
        t_power();
        t_option();
        t_timer();
        t_irq();
        t_periph();
        final_report();
    end
endmodule // core_status_option_irq_regs_tb
`default_nettype wire
